/* pkg/timer_pkg.sv */
// Shared constants and types for the capture/compare/PWM timer.
package timer_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses; each register is one aligned 32-bit word.
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CNT_HI    = 8'h00;
  localparam logic [7:0] ADDR_CNT_LO    = 8'h04;
  localparam logic [7:0] ADDR_RLD_HI    = 8'h08;
  localparam logic [7:0] ADDR_RLD_LO    = 8'h0C;
  localparam logic [7:0] ADDR_PWM_HI    = 8'h10;
  localparam logic [7:0] ADDR_PWM_LO    = 8'h14;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h18;
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'h1C;
  localparam logic [7:0] ADDR_CAPTURE   = 8'h20;
  localparam logic [7:0] ADDR_STATUS    = 8'h24;

  // ----------------------------------------------------------------------
  // Field positions of timer_ctrl_one and timer_ctrl_zero.
  // ----------------------------------------------------------------------
  localparam int ONE_ENABLE_BIT  = 7;
  localparam int ONE_POL_BIT     = 6;
  localparam int ONE_PRESCALE_EXPONENT_LSB    = 3;
  localparam int ONE_MODE_LSB    = 0;
  localparam int ZERO_IRQSEL_LSB = 5;
  localparam int ZERO_DEAD_LSB   = 1;
  localparam int ZERO_OUTALT_BIT = 0;

  // ----------------------------------------------------------------------
  // Values after reset and fixed counts.
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0]  CTRL_ZERO_RST = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [15:0] RELOAD_RST    = 16'h0000;
  localparam logic [15:0] PWM_RST       = 16'h0000;
  localparam logic [15:0] START_VALUE   = 16'h0001;
  localparam logic [6:0]  PRESC_RST     = 7'h00;
  localparam logic [2:0]  DEAD_RST      = 3'h0;

  // ----------------------------------------------------------------------
  // Operating modes.
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_CONTINUOUS = 3'h0;
  localparam logic [2:0] MODE_COUNTER    = 3'h1;
  localparam logic [2:0] MODE_CAP_RESTART = 3'h2;
  localparam logic [2:0] MODE_CAP_COMPARE = 3'h3;
  localparam logic [2:0] MODE_CMP_COUNTER = 3'h4;
  localparam logic [2:0] MODE_DUAL_PWM   = 3'h5;

  // Event selection codes of irq_event_select; 2'h3 behaves like both.
  localparam logic [1:0] IRQ_BOTH     = 2'h0;
  localparam logic [1:0] IRQ_CAP_ONLY = 2'h1;
  localparam logic [1:0] IRQ_RLD_ONLY = 2'h2;

  // Capture/compare start sequencing, Gray coded along idle-armed-run.
  typedef enum logic [1:0] {
    CC_IDLE  = 2'b00,
    CC_ARMED = 2'b01,
    CC_RUN   = 2'b11
  } cc_state_t;

endpackage : timer_pkg

/* design/timer_prescaler.sv */
// Power-of-two prescaler that produces one tick per divided period.
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic       clear_in,
  input  wire logic [2:0] exponent_in,
  output logic            tick_out
);

  logic [6:0] cnt_r;
  logic [6:0] mask;

  // Low exponent bits of the counter must all be ones for a tick.
  assign mask = 7'((8'h01 << exponent_in) - 8'h01);

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Clearing restarts alignment so a restarted timer sees a full period.
  always_ff @(posedge mclk_in) begin
    if (rst_in || clear_in) begin
      cnt_r    <= timer_pkg::PRESC_RST;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= 7'(cnt_r + 7'h01);
      tick_out <= ((cnt_r & mask) == mask);
    end
  end

  presc_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    clear_in |=> (cnt_r == 7'h00) && !tick_out) else $error("prescaler not cleared");
  presc_div2_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (exponent_in == 3'h1) && $stable(exponent_in) && !clear_in && tick_out ##1 !clear_in
    |-> !tick_out) else $error("divide by two ticked twice in a row");

endmodule : timer_prescaler
`default_nettype wire

/* design/cc_pwm_timer.sv */
// Capture/compare/PWM timer with an AHB-Lite register slave.
// Notes on behaviour
// - Capture/compare mode waits for the first active input edge before counting.
// - The starting edge in capture/compare mode raises no timer event.
// - Events on capture and reload by default; selectable capture only or reload only.
// - Reading count high while enabled latches count low into a holding register.
// - Reading count low while disabled returns the live counter.
// - Count reads never disturb counting or other timer operation.
// - Timer output toggles on every reload outside dual PWM mode.
// - Input shares the complement pin; no input in dual PWM mode.
// - Capture/compare uses rising edges for polarity 0, falling for polarity 1.
// - Dual PWM polarity 0: idle low/high, match high/low, reload low/high.
// - Dual PWM polarity 1 inverts every polarity 0 level.
// - Dual PWM deadband delays each output going to its active level.
// - Capture-restart captures on rising edge for polarity 0, falling for 1.
// - Comparator counter: output follows polarity when disabled, inverts on reload.
// - With output alternate function on, pin shows polarity even when disabled.
// - Changing polarity while running does not change the output immediately.
// - Prescaler divides by two to the power of the 3-bit exponent.
// - Prescaler clears whenever the timer is disabled.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module cc_pwm_timer (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        timer_in_in,
  output logic             timer_out_pin_out,
  output logic             timer_out_oe_n_out,
  output logic             timer_comp_out,
  output logic             timer_comp_oe_n_out,
  output logic             timer_event_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0]  timer_ctrl_one_r;
  logic [7:0]  timer_ctrl_zero_r;
  logic [15:0] count_r;
  logic [15:0] reload_r;
  logic [15:0] pwm_r;
  logic [15:0] capture_r;
  logic [7:0]  hold_lo_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic        in_d_r;
  logic [2:0]  dead_cnt_r;
  logic        pend_out_r;
  logic        pend_comp_r;
  timer_pkg::cc_state_t cc_state_r;
  logic        accept;
  logic        rd_acc;
  logic [7:0]  acc_addr;
  logic [31:0] rd_word;
  logic        en;
  logic        pol;
  logic [2:0]  mode;
  logic [2:0]  prescale_exponent;
  logic [1:0]  irq_event_select;
  logic [2:0]  pwm_deadband_delay;
  logic        out_alt_en;
  logic        presc_tick;
  logic        presc_clear;
  logic        act_edge;
  logic        edge_counting;
  logic        tick;
  logic        reload_ev;
  logic        match_ev;
  logic        cap_ev;
  logic        restart_ev;
  logic        wr_cnt;
  logic [7:0]  wdata;

  // Control fields.
  assign en                 = timer_ctrl_one_r[timer_pkg::ONE_ENABLE_BIT];
  assign pol                = timer_ctrl_one_r[timer_pkg::ONE_POL_BIT];
  assign prescale_exponent  = timer_ctrl_one_r[timer_pkg::ONE_PRESCALE_EXPONENT_LSB +: 3];
  assign mode               = timer_ctrl_one_r[timer_pkg::ONE_MODE_LSB +: 3];
  assign irq_event_select   = timer_ctrl_zero_r[timer_pkg::ZERO_IRQSEL_LSB +: 2];
  assign pwm_deadband_delay = timer_ctrl_zero_r[timer_pkg::ZERO_DEAD_LSB +: 3];
  assign out_alt_en         = timer_ctrl_zero_r[timer_pkg::ZERO_OUTALT_BIT];

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Zero wait states: read data is prepared in the address phase.
  assign accept   = hsel_in && htrans_in[1] && hready_in;
  assign rd_acc   = accept && !hwrite_in;
  assign acc_addr = haddr_in[7:0];
  assign wdata    = hwdata_in[7:0];
  assign wr_cnt   = wr_pend_r && ((wr_addr_r == timer_pkg::ADDR_CNT_HI) ||
                                  (wr_addr_r == timer_pkg::ADDR_CNT_LO));

  // Read multiplexer; unmapped offsets read as zero with an OKAY answer.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (acc_addr)
      timer_pkg::ADDR_CNT_HI:    rd_word[7:0] = count_r[15:8];
      timer_pkg::ADDR_CNT_LO:    rd_word[7:0] = en ? hold_lo_r : count_r[7:0];
      timer_pkg::ADDR_RLD_HI:    rd_word[7:0] = reload_r[15:8];
      timer_pkg::ADDR_RLD_LO:    rd_word[7:0] = reload_r[7:0];
      timer_pkg::ADDR_PWM_HI:    rd_word[7:0] = pwm_r[15:8];
      timer_pkg::ADDR_PWM_LO:    rd_word[7:0] = pwm_r[7:0];
      timer_pkg::ADDR_CTRL_ONE:  rd_word[7:0] = timer_ctrl_one_r;
      timer_pkg::ADDR_CTRL_ZERO: rd_word[7:0] = timer_ctrl_zero_r;
      timer_pkg::ADDR_CAPTURE:   rd_word[15:0] = capture_r;
      timer_pkg::ADDR_STATUS:    rd_word[2:0] = {timer_comp_out, timer_out_pin_out, (cc_state_r == timer_pkg::CC_RUN)};
      default:                   rd_word = 32'h0000_0000;
    endcase
  end

  // Bus phase tracking and answer registers.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      wr_pend_r     <= accept && hwrite_in;
      wr_addr_r     <= acc_addr;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      if (rd_acc) begin
        hrdata_out <= rd_word;
      end
    end
  end

  // Holding register; reads touch nothing but this latch.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      hold_lo_r <= 8'h00;
    end else if (rd_acc && en && (acc_addr == timer_pkg::ADDR_CNT_HI)) begin
      hold_lo_r <= count_r[7:0];
    end
  end

  // Configuration registers; disabling through timer_ctrl_one clears the prescaler and start state but keeps the count.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_ctrl_one_r  <= timer_pkg::CTRL_ONE_RST;
      timer_ctrl_zero_r <= timer_pkg::CTRL_ZERO_RST;
      reload_r          <= timer_pkg::RELOAD_RST;
      pwm_r             <= timer_pkg::PWM_RST;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        timer_pkg::ADDR_RLD_HI:    reload_r[15:8]    <= wdata;
        timer_pkg::ADDR_RLD_LO:    reload_r[7:0]     <= wdata;
        timer_pkg::ADDR_PWM_HI:    pwm_r[15:8]       <= wdata;
        timer_pkg::ADDR_PWM_LO:    pwm_r[7:0]        <= wdata;
        timer_pkg::ADDR_CTRL_ONE:  timer_ctrl_one_r  <= wdata;
        timer_pkg::ADDR_CTRL_ZERO: timer_ctrl_zero_r <= wdata;
        default:                   reload_r          <= reload_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Input edges and event sources
  // ----------------------------------------------------------------------
  // The pin belongs to the complement output in dual PWM, so edges are ignored there.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      in_d_r <= 1'b0;
    end else begin
      in_d_r <= timer_in_in;
    end
  end

  assign act_edge = (mode != timer_pkg::MODE_DUAL_PWM) &&
                    (pol ? (in_d_r && !timer_in_in) : (!in_d_r && timer_in_in));

  assign edge_counting = (mode == timer_pkg::MODE_COUNTER) || (mode == timer_pkg::MODE_CMP_COUNTER);

  // Capture/compare holds the prescaler clear until the start edge aligns it.
  assign presc_clear = !en || ((mode == timer_pkg::MODE_CAP_COMPARE) && (cc_state_r != timer_pkg::CC_RUN));

  always_comb begin
    tick = 1'b0;
    if (en) begin
      if (edge_counting) begin
        tick = act_edge;
      end else if (mode == timer_pkg::MODE_CAP_COMPARE) begin
        tick = presc_tick && (cc_state_r == timer_pkg::CC_RUN);
      end else begin
        tick = presc_tick;
      end
    end
  end

  assign reload_ev  = tick && (count_r == reload_r);
  assign match_ev   = tick && (count_r == pwm_r) && !reload_ev;
  assign cap_ev     = en && act_edge && (((mode == timer_pkg::MODE_CAP_COMPARE) &&
                      (cc_state_r == timer_pkg::CC_RUN)) || (mode == timer_pkg::MODE_CAP_RESTART));
  assign restart_ev = cap_ev && (mode == timer_pkg::MODE_CAP_RESTART);

  timer_prescaler u_prescaler (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .clear_in    (presc_clear),
    .exponent_in (prescale_exponent),
    .tick_out    (presc_tick)
  );

  // ----------------------------------------------------------------------
  // Capture/compare start sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in || !en || (mode != timer_pkg::MODE_CAP_COMPARE)) begin
      cc_state_r <= timer_pkg::CC_IDLE;
    end else begin
      unique case (cc_state_r)
        timer_pkg::CC_IDLE:  cc_state_r <= timer_pkg::CC_ARMED;
        timer_pkg::CC_ARMED: cc_state_r <= act_edge ? timer_pkg::CC_RUN : timer_pkg::CC_ARMED;
        timer_pkg::CC_RUN:   cc_state_r <= timer_pkg::CC_RUN;
        default:             cc_state_r <= timer_pkg::CC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Counter and capture
  // ----------------------------------------------------------------------
  // A software write wins over counting in the same cycle.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_r <= timer_pkg::COUNT_RST;
    end else if (wr_pend_r && (wr_addr_r == timer_pkg::ADDR_CNT_HI)) begin
      count_r[15:8] <= wdata;
    end else if (wr_pend_r && (wr_addr_r == timer_pkg::ADDR_CNT_LO)) begin
      count_r[7:0] <= wdata;
    end else if (restart_ev || reload_ev) begin
      count_r <= timer_pkg::START_VALUE;
    end else if (tick) begin
      count_r <= 16'(count_r + 16'h0001);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      capture_r <= timer_pkg::COUNT_RST;
    end else if (cap_ev) begin
      capture_r <= count_r;
    end
  end

  // Event output filtered by irq_event_select.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_event_out <= 1'b0;
    end else begin
      timer_event_out <= (cap_ev && (irq_event_select != timer_pkg::IRQ_RLD_ONLY)) ||
                         (reload_ev && (irq_event_select != timer_pkg::IRQ_CAP_ONLY));
    end
  end

  // ----------------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------------
  // Polarity is sampled only while disabled, at a dual PWM reload or match, or at a deadband end, so a change while running
  // shows in dual PWM at the next such point and in other modes only once disabled, never at once.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_out_pin_out <= 1'b0;
      timer_comp_out    <= 1'b1;
      dead_cnt_r        <= timer_pkg::DEAD_RST;
      pend_out_r        <= 1'b0;
      pend_comp_r       <= 1'b0;
    end else if (!en) begin
      timer_out_pin_out <= pol;
      timer_comp_out    <= !pol;
      dead_cnt_r        <= timer_pkg::DEAD_RST;
      pend_out_r        <= 1'b0;
      pend_comp_r       <= 1'b0;
    end else if (mode == timer_pkg::MODE_DUAL_PWM) begin
      if (reload_ev) begin
        timer_out_pin_out <= pol;
        pend_out_r        <= 1'b0;
        pend_comp_r       <= 1'b1;
        dead_cnt_r        <= pwm_deadband_delay;
      end else if (match_ev) begin
        timer_comp_out <= pol;
        pend_comp_r    <= 1'b0;
        pend_out_r     <= 1'b1;
        dead_cnt_r     <= pwm_deadband_delay;
      end else if (pend_out_r || pend_comp_r) begin
        if (dead_cnt_r == 3'h0) begin
          if (pend_out_r) begin
            timer_out_pin_out <= !pol;
          end
          if (pend_comp_r) begin
            timer_comp_out <= !pol;
          end
          pend_out_r  <= 1'b0;
          pend_comp_r <= 1'b0;
        end else begin
          dead_cnt_r <= 3'(dead_cnt_r - 3'h1);
        end
      end
    end else if (reload_ev) begin
      timer_out_pin_out <= !timer_out_pin_out;
    end
  end

  // Pin drivers follow the alternate function, the complement driver only in dual PWM, independent of any direction setting.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_out_oe_n_out  <= 1'b1;
      timer_comp_oe_n_out <= 1'b1;
    end else begin
      timer_out_oe_n_out  <= !out_alt_en;
      timer_comp_oe_n_out <= !(out_alt_en && (mode == timer_pkg::MODE_DUAL_PWM));
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  armed_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (cc_state_r == timer_pkg::CC_ARMED) && !wr_cnt |=> count_r == $past(count_r))
    else $error("counter moved before start edge");
  start_quiet_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    en && (cc_state_r == timer_pkg::CC_ARMED) && act_edge && !reload_ev |=> !timer_event_out)
    else $error("start edge raised an event");
  event_select_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (irq_event_select == timer_pkg::IRQ_CAP_ONLY) && !cap_ev |=> !timer_event_out)
    else $error("event outside capture only selection");
  hold_copy_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_acc && en && (acc_addr == timer_pkg::ADDR_CNT_HI) |=> hold_lo_r == $past(count_r[7:0]))
    else $error("holding register not loaded");
  live_low_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_acc && !en && (acc_addr == timer_pkg::ADDR_CNT_LO) |=> hrdata_out[7:0] == $past(count_r[7:0]))
    else $error("disabled low read not live");
  reload_toggle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    reload_ev && (mode != timer_pkg::MODE_DUAL_PWM) |=> timer_out_pin_out != $past(timer_out_pin_out))
    else $error("output did not toggle on reload");
  idle_level_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    !en |=> (timer_out_pin_out == $past(pol)) && (timer_comp_out != $past(pol)))
    else $error("idle output not at polarity");
  match_comp_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    en && (mode == timer_pkg::MODE_DUAL_PWM) && match_ev |=> timer_comp_out == $past(pol))
    else $error("complement not inactive on match");
  dead_zero_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    en && (mode == timer_pkg::MODE_DUAL_PWM) && match_ev && (pwm_deadband_delay == 3'h0) ##1
    !reload_ev && !match_ev && en |=> timer_out_pin_out == $past(!pol, 2))
    else $error("output not active after zero delay");

endmodule : cc_pwm_timer
`default_nettype wire

/* tb/pin_model.sv */
// Model of the external source that drives the timer input pin.
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  input  wire logic mclk_in,
  input  wire logic level_in,
  output logic      pin_out
);
  initial pin_out = 1'b0;
  // The pin follows the request one clock later, changing on the sampling edge through a nonblocking update.
  always @(posedge mclk_in) begin
    pin_out <= level_in;
  end
endmodule : pin_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the capture/compare/PWM timer.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH at %0t: %h vs %h", $time, a, b); end end
module tb;
  logic        mclk_in = 1'b0;
  logic        rst_in  = 1'b1;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        level   = 1'b0;
  logic        pin;
  logic [31:0] hrdata;
  logic        hready, hresp, tout, toe_n, comp, coe_n, evt, seen;
  logic [31:0] rd;
  int          mismatches = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          n;
  always #5 mclk_in = ~mclk_in;
  pin_model pm (.mclk_in(mclk_in), .level_in(level), .pin_out(pin));
  cc_pwm_timer uut (.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .timer_in_in(pin), .timer_out_pin_out(tout),
    .timer_out_oe_n_out(toe_n), .timer_comp_out(comp), .timer_comp_oe_n_out(coe_n), .timer_event_out(evt));
  // ----------------------------------------------------------------------
  // Bus and pin helpers.
  // ----------------------------------------------------------------------
  // One single AHB-Lite transfer; read data is taken at the edge ending the data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge mclk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  // Watches the event line for a fixed window.
  task automatic wait_evt(input int cnt);
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge mclk_in);
      if (evt === 1'b1) seen = 1'b1;
    end
  endtask : wait_evt
  // Software programs count and reload before the enabling write.
  task automatic setup(input logic [15:0] cnt, input logic [15:0] rld, input logic [7:0] z, input logic [7:0] o);
    bus(1'b1, timer_pkg::ADDR_CTRL_ONE, 32'h0);
    bus(1'b1, timer_pkg::ADDR_CNT_HI, {24'h0, cnt[15:8]});
    bus(1'b1, timer_pkg::ADDR_CNT_LO, {24'h0, cnt[7:0]});
    bus(1'b1, timer_pkg::ADDR_RLD_HI, {24'h0, rld[15:8]});
    bus(1'b1, timer_pkg::ADDR_RLD_LO, {24'h0, rld[7:0]});
    bus(1'b1, timer_pkg::ADDR_CTRL_ZERO, {24'h0, z});
    bus(1'b1, timer_pkg::ADDR_CTRL_ONE, {24'h0, o});
  endtask : setup
  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  task automatic t_prescale();
    setup(16'h0005, 16'hFFFF, 8'h00, 8'h98);
    repeat (80) @(posedge mclk_in);
    bus(1'b1, timer_pkg::ADDR_CTRL_ONE, 32'h18);
    bus(1'b0, timer_pkg::ADDR_CNT_LO, 32'h0);
    `CHK(rd[7:0] inside {[8'h0E:8'h10]}, 1'b1)
    bus(1'b1, timer_pkg::ADDR_CNT_LO, 32'h33);
    bus(1'b0, timer_pkg::ADDR_CNT_LO, 32'h0);
    `CHK(rd, 32'h33)
  endtask : t_prescale
  task automatic t_reload();
    setup(16'h0001, 16'h0010, 8'h00, 8'h80);
    `CHK(tout, 1'b0)
    // One reload period is sixteen ticks, so this window holds exactly one reload.
    wait_evt(24);
    `CHK(seen, 1'b1)
    repeat (2) @(posedge mclk_in);
    `CHK(tout, 1'b1)
    bus(1'b1, timer_pkg::ADDR_CTRL_ZERO, 32'h20);
    wait_evt(40);
    `CHK(seen, 1'b0)
    bus(1'b1, timer_pkg::ADDR_CTRL_ZERO, 32'h40);
    wait_evt(40);
    `CHK(seen, 1'b1)
  endtask : t_reload
  task automatic t_capture();
    setup(16'h0001, 16'hFFFF, 8'h00, 8'h83);
    repeat (20) @(posedge mclk_in);
    bus(1'b0, timer_pkg::ADDR_CNT_HI, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, timer_pkg::ADDR_CNT_LO, 32'h0);
    `CHK(rd, 32'h1)
    level <= 1'b1;
    wait_evt(6);
    `CHK(seen, 1'b0)
    repeat (20) @(posedge mclk_in);
    level <= 1'b0;
    wait_evt(6);
    `CHK(seen, 1'b0)
    level <= 1'b1;
    wait_evt(6);
    `CHK(seen, 1'b1)
    bus(1'b0, timer_pkg::ADDR_CAPTURE, 32'h0);
    `CHK(rd[15:0] > 16'h0010, 1'b1)
  endtask : t_capture
  // Capture-restart with polarity 1: the falling edge captures, the rising edge does nothing.
  task automatic t_restart();
    setup(16'h0001, 16'hFFFF, 8'h00, 8'hC2);
    repeat (10) @(posedge mclk_in);
    level <= 1'b0;
    wait_evt(6);
    `CHK(seen, 1'b1)
    bus(1'b0, timer_pkg::ADDR_CAPTURE, 32'h0);
    `CHK(rd, 32'h0000_000B)
    level <= 1'b1;
    wait_evt(6);
    `CHK(seen, 1'b0)
  endtask : t_restart
  // Comparator counter counts rising input edges; the second edge meets reload 2 and inverts the output.
  task automatic t_edge_count();
    setup(16'h0001, 16'h0002, 8'h00, 8'h84);
    repeat (2) begin
      level <= 1'b0;
      repeat (4) @(posedge mclk_in);
      level <= 1'b1;
      wait_evt(6);
    end
    `CHK({seen, tout}, 2'b11)
  endtask : t_edge_count
  task automatic t_pwm();
    setup(16'h0001, 16'h0010, 8'h01, 8'h05);
    repeat (3) @(posedge mclk_in);
    `CHK({tout, comp, toe_n, coe_n}, 4'b0100)
    bus(1'b1, timer_pkg::ADDR_CTRL_ONE, 32'h45);
    repeat (3) @(posedge mclk_in);
    `CHK({tout, comp}, 2'b10)
    bus(1'b1, timer_pkg::ADDR_CTRL_ONE, 32'h44);
    repeat (3) @(posedge mclk_in);
    `CHK({tout, toe_n}, 2'b10)
    bus(1'b1, timer_pkg::ADDR_PWM_LO, 32'h08);
    setup(16'h0001, 16'h0010, 8'h07, 8'h85);
    n = 0;
    do begin @(posedge mclk_in); n++; end while (comp !== 1'b0 && n < 60);
    n = 0;
    do begin @(posedge mclk_in); n++; end while (tout !== 1'b1 && n < 20);
    `CHK(n, 4)
    `CHK(comp, 1'b0)
  endtask : t_pwm
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // A hang is cut short after a generous multiple of the expected run.
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    `CHK({tout, comp, toe_n, hready, hresp}, 5'b01110)
    t_prescale();
    t_reload();
    t_capture();
    t_restart();
    t_edge_count();
    t_pwm();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
